// ### rtl/cim_irq_power.sv
// Interrupt flags, vectors, configuration lock and low-power mode control of a CAN controller.
//
// Contract
// - Each of three transmit buffers has an empty flag, gated by its own enable, requesting the shared transmit interrupt.
// - An accepted frame sets receive-full and requests receive interrupt right after end-of-frame.
// - Bus activity in sleep sets wake flag; interrupt needs wake flag and enable both set.
// - Receive error counter reaching 96 sets the receiver warning flag.
// - Transmit error counter reaching 96 sets the transmitter warning flag.
// - Receive error counter above 127 means error passive and sets its flag.
// - Transmit error counter above 127 means error passive and sets its flag.
// - Transmit error counter above 255 means bus-off and sets the bus-off flag.
// - Accepted frame with both receive buffers full is dropped and sets overrun.
// - Eleven masked sources feed four vectors held while any enabled flag stays set.
// - Writing one clears a flag, unless its setting condition still holds.
// - Error counters cannot be written or changed through the registers.
// - Configuration registers accept writes only while soft reset is set.
// - Every low-power mode holds the bus transmit output recessive.
// - Mode chosen from processor stop, wait, stop-in-wait, sleep acknowledge and soft reset.
// - Sleep request waits for queued transmits and current reception, else sleeps at once.
// - In sleep: acknowledge set, clocks stopped, flag access kept, no copy or abort.
// - Bus-off recovery counting pauses in sleep and resumes afterwards.
// - Sleep ends on bus activity, request cleared, or soft reset set.
// - Clearing sleep request is ignored until sleep acknowledge reads one.
// - After wake-up wait 11 recessive bits before joining; then run pending work.
// - Setting soft reset stops transmission and reception at once.
// - Power-down stops everything, aborts traffic and blocks all register access.
`timescale 1ns/1ns
`default_nettype none
module cim_irq_power (
    input wire logic mclk,
    input wire logic reset,
    input wire logic cpu_stop,
    input wire logic cpu_wait,
    input wire logic ctl_wr,
    input wire logic ctl_soft_reset,
    input wire logic ctl_sleep_req,
    input wire logic ctl_stop_in_wait,
    input wire logic rx_enable_wr,
    input wire logic [cim_pkg::N_RXFLAG-1:0] rx_enable_wdata,
    input wire logic tx_enable_wr,
    input wire logic [cim_pkg::N_TXBUF-1:0] tx_enable_wdata,
    input wire logic rx_flag_wr,
    input wire logic [cim_pkg::N_RXFLAG-1:0] rx_flag_wdata,
    input wire logic tx_flag_wr,
    input wire logic [cim_pkg::N_TXBUF-1:0] tx_flag_wdata,
    input wire cim_pkg::cim_cfg_wr_t cfg_wr,
    input wire cim_pkg::cim_err_cnt_t err_cnt,
    input wire logic [cim_pkg::N_TXBUF-1:0] tx_done,
    input wire logic rx_accept,
    input wire logic rx_busy,
    input wire logic tx_busy,
    input wire logic bus_activity,
    input wire logic bit_tick,
    input wire logic rx_recessive,
    input wire logic engine_tx,
    output logic [cim_pkg::N_RXFLAG-1:0] receiver_flag_reg,
    output logic [cim_pkg::N_TXBUF-1:0] transmitter_flag_reg,
    output logic [cim_pkg::N_RXFLAG-1:0] rx_enable_q,
    output logic [cim_pkg::N_TXBUF-1:0] tx_enable_q,
    output logic soft_reset_bit,
    output logic sleep_request_bit,
    output logic sleep_ack_flag,
    output logic stop_in_wait_bit,
    output cim_pkg::cim_mode_t mode_q,
    output logic irq_wake,
    output logic irq_error,
    output logic irq_rx,
    output logic irq_tx,
    output logic bus_tx_output,
    output logic engine_run_q,
    output logic bus_off_state,
    output logic error_passive_q,
    output logic recovery_count_en_q,
    output logic copy_abort_en_q,
    output logic [cim_pkg::CFG_REGS*8-1:0] cfg_regs_q
);
    function automatic cim_pkg::cim_mode_t mode_of(input logic stop, input logic wt, input logic siw,
                                                   input logic ack, input logic sr);
        if (stop || (wt && siw)) begin
            return cim_pkg::CIM_POWER_DOWN;
        end else if (sr) begin
            return cim_pkg::CIM_SOFT_RESET;
        end else if (ack) begin
            return cim_pkg::CIM_SLEEP;
        end else begin
            return cim_pkg::CIM_NORMAL;
        end
    endfunction : mode_of

    function automatic logic above(input logic [cim_pkg::TX_CNT_W-1:0] cnt,
                                   input logic [cim_pkg::TX_CNT_W-1:0] limit);
        return cnt > limit;
    endfunction : above

    cim_pkg::cim_mode_t mode_d;
    logic power_down;
    logic acc_ok;
    logic ctl_take;
    logic wake_event;
    logic leave_sleep;
    logic enter_sleep;
    logic [cim_pkg::TX_CNT_W-1:0] rx_cnt_w;
    logic [cim_pkg::TX_CNT_W-1:0] tx_cnt_w;
    logic [cim_pkg::N_RXFLAG-1:0] rcond;
    logic [cim_pkg::N_RXFLAG-1:0] rcond_q;
    logic [cim_pkg::N_RXFLAG-1:0] rset;
    logic [cim_pkg::N_RXFLAG-1:0] rclr;
    logic [cim_pkg::N_TXBUF-1:0] tclr;
    logic bg_full_q;
    logic rx_take;
    logic copy_now;
    logic [cim_pkg::RESYNC_W-1:0] resync_q;
    logic synced_q;
    logic running;

    // Error counters come from the protocol engine only; no write path exists here.
    assign rx_cnt_w = {1'b0, err_cnt.rx};
    assign tx_cnt_w = err_cnt.tx;

    assign power_down = cpu_stop | (cpu_wait & stop_in_wait_bit);
    assign mode_d = mode_of(cpu_stop, cpu_wait, stop_in_wait_bit, sleep_ack_flag, soft_reset_bit);
    assign acc_ok = ~power_down;
    assign ctl_take = ctl_wr & acc_ok;
    assign running = engine_run_q & (mode_d == cim_pkg::CIM_NORMAL);

    // Sleep is entered only when nothing is queued or moving on the bus.
    assign enter_sleep = sleep_request_bit & ~sleep_ack_flag & ~soft_reset_bit & ~power_down
                         & (&transmitter_flag_reg) & ~tx_busy & ~rx_busy;
    assign wake_event = sleep_ack_flag & bus_activity & ~power_down;
    assign leave_sleep = wake_event
                         | (ctl_take & ~ctl_sleep_req & sleep_ack_flag)
                         | (ctl_take & ctl_soft_reset);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            soft_reset_bit <= cim_pkg::SOFT_RESET_INIT;
            stop_in_wait_bit <= 1'b0;
        end else if (ctl_take) begin
            soft_reset_bit <= ctl_soft_reset;
            stop_in_wait_bit <= ctl_stop_in_wait;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleep_request_bit <= 1'b0;
        end else if (wake_event) begin
            sleep_request_bit <= 1'b0;
        end else if (ctl_take && (ctl_sleep_req || sleep_ack_flag)) begin
            sleep_request_bit <= ctl_sleep_req;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleep_ack_flag <= 1'b0;
        end else if (leave_sleep) begin
            sleep_ack_flag <= 1'b0;
        end else if (enter_sleep) begin
            sleep_ack_flag <= 1'b1;
        end
    end

    // Rejoining the bus needs a run of recessive bits after any non-normal spell.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            resync_q <= cim_pkg::RESYNC_ZERO;
            synced_q <= 1'b0;
        end else if (mode_d != cim_pkg::CIM_NORMAL) begin
            resync_q <= cim_pkg::RESYNC_ZERO;
            synced_q <= 1'b0;
        end else if (!synced_q && bit_tick) begin
            if (!rx_recessive) begin
                resync_q <= cim_pkg::RESYNC_ZERO;
            end else if (resync_q == cim_pkg::RESYNC_BITS - cim_pkg::RESYNC_ONE) begin
                synced_q <= 1'b1;
            end else begin
                resync_q <= resync_q + cim_pkg::RESYNC_ONE;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mode_q <= cim_pkg::CIM_POWER_DOWN;
            engine_run_q <= 1'b0;
            bus_tx_output <= cim_pkg::RECESSIVE;
            copy_abort_en_q <= 1'b0;
            recovery_count_en_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            engine_run_q <= (mode_d == cim_pkg::CIM_NORMAL) & synced_q;
            bus_tx_output <= running ? engine_tx : cim_pkg::RECESSIVE;
            copy_abort_en_q <= mode_d == cim_pkg::CIM_NORMAL;
            recovery_count_en_q <= bus_off_state & (mode_d == cim_pkg::CIM_NORMAL);
        end
    end

    // Receive path: foreground full flag plus a background slot; a third frame is lost.
    assign rx_take = rx_accept & running;
    assign copy_now = bg_full_q & ~receiver_flag_reg[cim_pkg::RF_RXF] & (mode_d == cim_pkg::CIM_NORMAL);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bg_full_q <= 1'b0;
        end else if (mode_d == cim_pkg::CIM_SOFT_RESET || mode_d == cim_pkg::CIM_POWER_DOWN) begin
            bg_full_q <= 1'b0;
        end else if (copy_now) begin
            // A frame taken on the copy cycle refills the background slot instead of vanishing.
            bg_full_q <= rx_take;
        end else if (rx_take && receiver_flag_reg[cim_pkg::RF_RXF]) begin
            bg_full_q <= 1'b1;
        end
    end

    always_comb begin
        rcond = '0;
        rcond[cim_pkg::RF_RWRN] = rx_cnt_w >= cim_pkg::WARN_LIMIT;
        rcond[cim_pkg::RF_TWRN] = tx_cnt_w >= cim_pkg::WARN_LIMIT;
        rcond[cim_pkg::RF_RERR] = above(rx_cnt_w, cim_pkg::PASSIVE_LIMIT);
        rcond[cim_pkg::RF_TERR] = above(tx_cnt_w, cim_pkg::PASSIVE_LIMIT);
        rcond[cim_pkg::RF_BOFF] = above(tx_cnt_w, cim_pkg::BUS_OFF_LIMIT);
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rcond_q <= '0;
            error_passive_q <= 1'b0;
            bus_off_state <= 1'b0;
        end else begin
            rcond_q <= rcond;
            error_passive_q <= rcond[cim_pkg::RF_RERR] | rcond[cim_pkg::RF_TERR];
            bus_off_state <= rcond[cim_pkg::RF_BOFF];
        end
    end

    always_comb begin
        rset = rcond & ~rcond_q;
        rset[cim_pkg::RF_RXF] = (rx_take & ~receiver_flag_reg[cim_pkg::RF_RXF]) | copy_now;
        rset[cim_pkg::RF_OVR] = rx_take & receiver_flag_reg[cim_pkg::RF_RXF] & bg_full_q;
        rset[cim_pkg::RF_WAKE] = wake_event;
    end

    assign rclr = rx_flag_wr & acc_ok ? rx_flag_wdata : '0;
    assign tclr = tx_flag_wr & acc_ok ? tx_flag_wdata : '0;

    cim_flag_cells #(.W(cim_pkg::N_RXFLAG), .INIT('0)) u_rx_flags (
        .mclk(mclk),
        .reset(reset),
        .set(rset),
        .hold(rcond),
        .clr(rclr),
        .flag_q(receiver_flag_reg)
    );

    cim_flag_cells #(.W(cim_pkg::N_TXBUF), .INIT(cim_pkg::TXE_INIT)) u_tx_flags (
        .mclk(mclk),
        .reset(reset),
        .set(tx_done),
        .hold('0),
        .clr(tclr),
        .flag_q(transmitter_flag_reg)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_enable_q <= cim_pkg::RX_ENABLE_INIT;
            tx_enable_q <= cim_pkg::TX_ENABLE_INIT;
        end else begin
            if (rx_enable_wr && acc_ok) begin
                rx_enable_q <= rx_enable_wdata;
            end
            if (tx_enable_wr && acc_ok) begin
                tx_enable_q <= tx_enable_wdata;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_wake <= 1'b0;
            irq_error <= 1'b0;
            irq_rx <= 1'b0;
            irq_tx <= 1'b0;
        end else begin
            irq_wake <= receiver_flag_reg[cim_pkg::RF_WAKE] & rx_enable_q[cim_pkg::RF_WAKE];
            irq_error <= |(receiver_flag_reg & rx_enable_q & cim_pkg::ERR_FLAGS_MASK);
            irq_rx <= receiver_flag_reg[cim_pkg::RF_RXF] & rx_enable_q[cim_pkg::RF_RXF];
            irq_tx <= |(transmitter_flag_reg & tx_enable_q);
        end
    end

    // Locked configuration bytes, writable only under soft reset.
    for (genvar i = 0; i < cim_pkg::CFG_REGS; i++) begin : g_cfg
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                cfg_regs_q[i*8 +: 8] <= cim_pkg::CFG_INIT;
            end else if (cfg_wr.valid && soft_reset_bit && acc_ok
                         && cfg_wr.index == cim_pkg::CFG_IDX_W'(i)) begin
                cfg_regs_q[i*8 +: 8] <= cfg_wr.data;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_low_power_recessive: assert property (
        mode_d != cim_pkg::CIM_NORMAL |=> bus_tx_output == cim_pkg::RECESSIVE)
        else $error("transmit output not recessive in a low-power mode");

    a_cfg_lock_held: assert property (
        cfg_wr.valid && !soft_reset_bit |=> $stable(cfg_regs_q))
        else $error("configuration changed while soft reset was clear");

    a_rx_warning_set: assert property (
        rx_cnt_w >= cim_pkg::WARN_LIMIT && !rcond_q[cim_pkg::RF_RWRN] |=> receiver_flag_reg[cim_pkg::RF_RWRN])
        else $error("receiver warning flag missed");

    a_bus_off_flag: assert property (
        $rose(rcond[cim_pkg::RF_BOFF]) |=> receiver_flag_reg[cim_pkg::RF_BOFF] && bus_off_state)
        else $error("bus-off flag or state missed");

    a_clear_blocked: assert property (
        receiver_flag_reg[cim_pkg::RF_TERR] && rcond[cim_pkg::RF_TERR] |=> receiver_flag_reg[cim_pkg::RF_TERR])
        else $error("flag cleared while its condition held");

    a_error_vector: assert property (
        ##1 irq_error == $past(|(receiver_flag_reg & rx_enable_q & cim_pkg::ERR_FLAGS_MASK)))
        else $error("error vector does not follow enabled flags");

    a_overrun_drop: assert property (
        rx_take && receiver_flag_reg[cim_pkg::RF_RXF] && bg_full_q && !copy_now
        |=> receiver_flag_reg[cim_pkg::RF_OVR] && bg_full_q)
        else $error("overrun not flagged on third frame");

    a_sleep_req_kept: assert property (
        ctl_take && !ctl_sleep_req && sleep_request_bit && !sleep_ack_flag && !wake_event
        |=> sleep_request_bit)
        else $error("sleep request cleared before acknowledge");

    a_sleep_waits_tx: assert property (
        sleep_request_bit && !sleep_ack_flag && (tx_busy || !(&transmitter_flag_reg)) |=> !sleep_ack_flag)
        else $error("sleep entered with transmission pending");

    a_wake_in_sleep: assert property (
        $rose(receiver_flag_reg[cim_pkg::RF_WAKE]) |-> $past(sleep_ack_flag))
        else $error("wake flag set outside sleep");

    a_resync_before_run: assert property (
        $rose(engine_run_q) |-> $past(synced_q) && $past(resync_q, 2) == cim_pkg::RESYNC_BITS - cim_pkg::RESYNC_ONE)
        else $error("engine rejoined without recessive run");

    a_soft_reset_stop: assert property (
        soft_reset_bit |=> !engine_run_q)
        else $error("engine running under soft reset");
endmodule : cim_irq_power
`default_nettype wire

// ### rtl/cim_pkg.sv
// Package with the constants and carrier types of the CAN interrupt and power-mode block.
`default_nettype none
package cim_pkg;
    localparam int unsigned RX_CNT_W = 8;
    localparam int unsigned TX_CNT_W = 9;
    localparam int unsigned N_TXBUF = 3;
    localparam int unsigned N_RXFLAG = 8;
    localparam int unsigned CFG_REGS = 20;
    localparam int unsigned CFG_IDX_W = 5;
    localparam int unsigned RESYNC_W = 4;

    // Error-counter limits, compared at the transmit counter width.
    localparam logic [TX_CNT_W-1:0] WARN_LIMIT = 9'h060;
    localparam logic [TX_CNT_W-1:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [TX_CNT_W-1:0] BUS_OFF_LIMIT = 9'h0FF;

    // Consecutive recessive bits needed to rejoin the bus.
    localparam logic [RESYNC_W-1:0] RESYNC_BITS = 4'hB;
    localparam logic [RESYNC_W-1:0] RESYNC_ONE = 4'h1;
    localparam logic [RESYNC_W-1:0] RESYNC_ZERO = 4'h0;

    // Bit positions in receiver_flag_reg and in its enable byte.
    localparam int unsigned RF_RXF = 0;
    localparam int unsigned RF_OVR = 1;
    localparam int unsigned RF_BOFF = 2;
    localparam int unsigned RF_TERR = 3;
    localparam int unsigned RF_RERR = 4;
    localparam int unsigned RF_TWRN = 5;
    localparam int unsigned RF_RWRN = 6;
    localparam int unsigned RF_WAKE = 7;
    localparam logic [N_RXFLAG-1:0] ERR_FLAGS_MASK = 8'h7E;

    localparam logic RECESSIVE = 1'b1;
    localparam logic SOFT_RESET_INIT = 1'b1;
    localparam logic [N_RXFLAG-1:0] RX_ENABLE_INIT = 8'h00;
    localparam logic [N_TXBUF-1:0] TX_ENABLE_INIT = 3'h0;
    localparam logic [N_TXBUF-1:0] TXE_INIT = 3'h7;
    localparam logic [7:0] CFG_INIT = 8'h00;

    typedef enum logic [1:0] {
        CIM_NORMAL,
        CIM_SLEEP,
        CIM_SOFT_RESET,
        CIM_POWER_DOWN
    } cim_mode_t;

    typedef struct packed {
        logic valid;
        logic [CFG_IDX_W-1:0] index;
        logic [7:0] data;
    } cim_cfg_wr_t;

    typedef struct packed {
        logic [RX_CNT_W-1:0] rx;
        logic [TX_CNT_W-1:0] tx;
    } cim_err_cnt_t;
endpackage : cim_pkg
`default_nettype wire

// ### rtl/cim_flag_cells.sv
// Array of sticky flags: set wins, write-one clears, a live condition blocks the clear.
`timescale 1ns/1ns
`default_nettype none
module cim_flag_cells #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] hold,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flag_q
);
    for (genvar i = 0; i < W; i++) begin : g_cell
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                flag_q[i] <= INIT[i];
            end else begin
                flag_q[i] <= set[i] | (flag_q[i] & ~(clr[i] & ~hold[i]));
            end
        end
    end
endmodule : cim_flag_cells
`default_nettype wire

// ### dv/cim_engine_model.sv
// Behavioural protocol engine and bus on the far side of the interrupt and power block.
`timescale 1ns/1ns
`default_nettype none
module cim_engine_model (
    input wire logic mclk,
    output cim_pkg::cim_err_cnt_t err_cnt,
    output logic [2:0] tx_done,
    output logic rx_accept,
    output logic rx_busy,
    output logic tx_busy,
    output logic bus_activity,
    output logic bit_tick,
    output logic rx_recessive,
    output logic engine_tx
);
    logic [1:0] div_q = 2'h0;
    initial begin
        err_cnt = '0;
        tx_done = 3'h0;
        rx_accept = 1'b0;
        rx_busy = 1'b0;
        tx_busy = 1'b0;
        bus_activity = 1'b0;
    end
    // A bit lasts four clocks; the idle bus reads recessive through its termination.
    always @(posedge mclk) begin
        div_q <= div_q + 2'h1;
    end
    always_comb bit_tick = (div_q == 2'h3);
    always_comb rx_recessive = !bus_activity;
    // The engine always asks for a dominant level, so forcing to recessive is visible.
    always_comb engine_tx = ~cim_pkg::RECESSIVE;
    task automatic pulse(input logic acc, input logic [2:0] done);
        rx_accept = acc;
        tx_done = done;
        @(negedge mclk);
        rx_accept = 1'b0;
        tx_done = 3'h0;
    endtask : pulse
    task automatic set_cnt(input logic [7:0] rx, input logic [8:0] tx);
        err_cnt.rx = rx;
        err_cnt.tx = tx;
    endtask : set_cnt
    task automatic set_busy(input logic t, input logic r);
        tx_busy = t;
        rx_busy = r;
    endtask : set_busy
    task automatic wake;
        bus_activity = 1'b1;
        @(negedge mclk);
        bus_activity = 1'b0;
    endtask : wake
endmodule : cim_engine_model
`default_nettype wire

// ### dv/cim_irq_power_tb.sv
// Self-checking testbench of the CAN interrupt and power-mode block.
`timescale 1ns/1ns
`default_nettype none
module cim_irq_power_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cpu_stop = 1'b0, cpu_wait = 1'b0;
    logic ctl_wr = 1'b0, ctl_soft_reset = 1'b0, ctl_sleep_req = 1'b0, ctl_stop_in_wait = 1'b0;
    logic rx_enable_wr = 1'b0, rx_flag_wr = 1'b0, tx_enable_wr = 1'b0, tx_flag_wr = 1'b0;
    logic [7:0] rx_enable_wdata = 8'h00, rx_flag_wdata = 8'h00;
    logic [2:0] tx_enable_wdata = 3'h0, tx_flag_wdata = 3'h0;
    cim_pkg::cim_cfg_wr_t cfg_wr = '0;
    cim_pkg::cim_err_cnt_t err_cnt;
    cim_pkg::cim_mode_t mode_q;
    logic [2:0] tx_done, transmitter_flag_reg, tx_enable_q;
    logic [7:0] receiver_flag_reg, rx_enable_q;
    logic [159:0] cfg_regs_q;
    logic rx_accept, rx_busy, tx_busy, bus_activity, bit_tick, rx_recessive, engine_tx;
    logic soft_reset_bit, sleep_request_bit, sleep_ack_flag, stop_in_wait_bit;
    logic irq_wake, irq_error, irq_rx, irq_tx, bus_tx_output, engine_run_q, bus_off_state;
    logic error_passive_q, recovery_count_en_q, copy_abort_en_q;
    int fails = 0;
    int n_compared = 0;

    cim_engine_model eng (.mclk, .err_cnt, .tx_done, .rx_accept, .rx_busy, .tx_busy, .bus_activity,
        .bit_tick, .rx_recessive, .engine_tx);
    cim_irq_power DUT (.mclk, .reset, .cpu_stop, .cpu_wait, .ctl_wr, .ctl_soft_reset, .ctl_sleep_req,
        .ctl_stop_in_wait, .rx_enable_wr, .rx_enable_wdata, .tx_enable_wr, .tx_enable_wdata, .rx_flag_wr,
        .rx_flag_wdata, .tx_flag_wr, .tx_flag_wdata, .cfg_wr, .err_cnt, .tx_done, .rx_accept, .rx_busy,
        .tx_busy, .bus_activity, .bit_tick, .rx_recessive, .engine_tx, .receiver_flag_reg,
        .transmitter_flag_reg, .rx_enable_q, .tx_enable_q, .soft_reset_bit, .sleep_request_bit,
        .sleep_ack_flag, .stop_in_wait_bit, .mode_q, .irq_wake, .irq_error, .irq_rx, .irq_tx,
        .bus_tx_output, .engine_run_q, .bus_off_state, .error_passive_q, .recovery_count_en_q,
        .copy_abort_en_q, .cfg_regs_q);

    always #5 mclk = ~mclk;

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic ctl(input logic s, input logic q, input logic w);
        ctl_soft_reset = s;
        ctl_sleep_req = q;
        ctl_stop_in_wait = w;
        ctl_wr = 1'b1;
        tick(1);
        ctl_wr = 1'b0;
    endtask : ctl

    // Writes the enable bytes, or clears flags when clr is set.
    task automatic wr(input logic clr, input logic [7:0] r, input logic [2:0] t);
        rx_enable_wr = !clr;
        tx_enable_wr = !clr;
        rx_flag_wr = clr;
        tx_flag_wr = clr;
        {rx_enable_wdata, rx_flag_wdata, tx_enable_wdata, tx_flag_wdata} = {r, r, t, t};
        tick(1);
        {rx_enable_wr, tx_enable_wr, rx_flag_wr, tx_flag_wr} = 4'h0;
        tick(2);
    endtask : wr

    task automatic wait_on(input int which);
        for (int i = 0; i < 100; i++) begin
            if ((which == 0 ? engine_run_q : sleep_ack_flag) === 1'b1) return;
            tick(1);
        end
        fails++;
        $display("ERROR at %0t: wait ran out", $time);
        complete_run();
    endtask : wait_on

    task automatic s_cfg;
        cfg_wr = '{1'b1, 5'h03, 8'hA5};
        tick(1);
        cfg_wr = '0;
        chk(cfg_regs_q[31:24], 8'hA5);
        ctl(1'b0, 1'b0, 1'b0);
        tick(1);
        chk(mode_q, cim_pkg::CIM_NORMAL);
        cfg_wr = '{1'b1, 5'h04, 8'h5A};
        tick(1);
        cfg_wr = '0;
        chk(cfg_regs_q[39:32], 8'h00);
        tick(14);
        chk(engine_run_q, 1'b0);
        wait_on(0);
    endtask : s_cfg

    task automatic s_tx;
        wr(1'b0, 8'h03, 3'h1);
        chk({rx_enable_q, tx_enable_q, irq_tx, bus_tx_output}, 13'h0066);
        wr(1'b1, 8'h00, 3'h0);
        chk(transmitter_flag_reg, 3'h7);
        wr(1'b1, 8'h00, 3'h1);
        chk({transmitter_flag_reg, irq_tx}, 4'hC);
        eng.pulse(1'b0, 3'h1);
        tick(2);
        chk({transmitter_flag_reg, irq_tx}, 4'hF);
    endtask : s_tx

    task automatic s_rx;
        eng.pulse(1'b1, 3'h0);
        tick(2);
        chk({receiver_flag_reg, irq_rx, irq_error}, 10'h006);
        eng.pulse(1'b1, 3'h0);
        tick(1);
        eng.pulse(1'b1, 3'h0);
        tick(2);
        chk({receiver_flag_reg, irq_error}, 9'h007);
        wr(1'b1, 8'h03, 3'h0);
        tick(1);
        chk(receiver_flag_reg, 8'h01);
        wr(1'b1, 8'h01, 3'h0);
        tick(1);
        chk({receiver_flag_reg, irq_rx, irq_error}, 10'h000);
    endtask : s_rx

    task automatic s_err;
        wr(1'b0, 8'h7E, 3'h0);
        eng.set_cnt(8'h5F, 9'h05F);
        tick(3);
        chk(receiver_flag_reg, 8'h00);
        eng.set_cnt(8'h60, 9'h060);
        tick(3);
        chk({receiver_flag_reg, irq_error}, 9'h0C1);
        eng.set_cnt(8'h80, 9'h080);
        tick(3);
        chk({receiver_flag_reg, error_passive_q}, 9'h0F1);
        eng.set_cnt(8'h80, 9'h100);
        tick(3);
        chk({receiver_flag_reg, bus_off_state, recovery_count_en_q}, 10'h1F3);
        wr(1'b1, 8'h7E, 3'h0);
        chk(receiver_flag_reg, 8'h7C);
        eng.set_cnt(8'h00, 9'h000);
        tick(3);
        wr(1'b1, 8'h7E, 3'h0);
        tick(1);
        chk({receiver_flag_reg, irq_error}, 9'h000);
    endtask : s_err

    task automatic s_sleep;
        wr(1'b0, 8'h80, 3'h0);
        eng.set_busy(1'b1, 1'b0);
        ctl(1'b0, 1'b1, 1'b0);
        tick(3);
        chk({sleep_request_bit, sleep_ack_flag}, 2'h2);
        ctl(1'b0, 1'b0, 1'b0);
        chk(sleep_request_bit, 1'b1);
        eng.set_busy(1'b0, 1'b1);
        tick(2);
        chk(sleep_ack_flag, 1'b0);
        eng.set_busy(1'b0, 1'b0);
        wait_on(1);
        tick(2);
        chk({mode_q, bus_tx_output, copy_abort_en_q}, {cim_pkg::CIM_SLEEP, 2'h2});
        eng.wake();
        tick(2);
        chk({receiver_flag_reg, sleep_request_bit, sleep_ack_flag, irq_wake}, 11'h401);
        wr(1'b1, 8'h80, 3'h0);
        ctl(1'b0, 1'b1, 1'b0);
        wait_on(1);
        ctl(1'b0, 1'b0, 1'b0);
        chk({sleep_request_bit, sleep_ack_flag}, 2'h0);
        tick(1);
        ctl(1'b0, 1'b1, 1'b0);
        wait_on(1);
        ctl(1'b1, 1'b1, 1'b0);
        tick(2);
        chk({mode_q, sleep_ack_flag}, {cim_pkg::CIM_SOFT_RESET, 1'b0});
    endtask : s_sleep

    task automatic s_pd;
        ctl(1'b1, 1'b0, 1'b1);
        cpu_wait = 1'b1;
        tick(2);
        chk({mode_q, bus_tx_output}, {cim_pkg::CIM_POWER_DOWN, 1'b1});
        ctl(1'b0, 1'b0, 1'b0);
        chk({soft_reset_bit, stop_in_wait_bit}, 2'h3);
        cpu_wait = 1'b0;
        cpu_stop = 1'b1;
        tick(2);
        chk(mode_q, cim_pkg::CIM_POWER_DOWN);
    endtask : s_pd

    initial begin
        tick(10);
        reset = 1'b0;
        tick(2);
        chk({soft_reset_bit, transmitter_flag_reg, bus_tx_output}, 5'h1F);
        chk(mode_q, cim_pkg::CIM_SOFT_RESET);
        s_cfg();
        s_tx();
        s_rx();
        s_err();
        s_sleep();
        s_pd();
        complete_run();
    end
endmodule : cim_irq_power_tb
`default_nettype wire
